// ===== src/drive_cmd_pkg.sv
`default_nettype none

package drive_cmd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // APB register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_DCB_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_DCB_FREQ   = 8'h0c;
  localparam logic [7:0] ADDR_CMPD_CUR   = 8'h10;
  localparam logic [7:0] ADDR_SW_STOP    = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int CTRL_W          = 10;
  localparam int CTRL_SCHEME_LSB = 0;
  localparam int CTRL_VARIANT    = 2;
  localparam int CTRL_DCB_DIN    = 3;
  localparam int CTRL_ROLE_A_LSB = 4;
  localparam int CTRL_ROLE_B_LSB = 6;
  localparam int CTRL_ROLE_C_LSB = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h240;

  // Software stop bits
  localparam int SW_COAST = 0;
  localparam int SW_FAST  = 1;

  // Status register fields
  localparam int STAT_MODE_LSB  = 0;
  localparam int STAT_REV       = 3;
  localparam int STAT_DCB       = 4;
  localparam int STAT_CMPD      = 5;
  localparam int STAT_ZERO      = 6;
  localparam int STAT_PINS_LSB  = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and reset values
  localparam int NUM_DIN  = 4;
  localparam int NUM_PINS = 6;
  localparam int PIN_COAST = 4;
  localparam int PIN_FAST  = 5;
  // Synchroniser reset: run contacts open, stop pins released
  localparam logic [NUM_PINS-1:0] PINS_RST = 6'h30;
  localparam int FREQ_W   = 16;
  localparam int PERIOD_W = 32;
  localparam logic [PERIOD_W-1:0] DCB_PERIOD_RST = 32'h0;
  localparam logic [FREQ_W-1:0]   DCB_FREQ_RST   = 16'h0;
  localparam logic [FREQ_W-1:0]   CMPD_CUR_RST   = 16'h0;

  // Control schemes
  localparam logic [1:0] SCHEME_LEVEL    = 2'h0;
  localparam logic [1:0] SCHEME_TWO_WIRE = 2'h1;
  localparam logic [1:0] SCHEME_PULSE    = 2'h2;
  localparam logic [1:0] SCHEME_HOLD     = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_RAMP_STOP,
    ST_FAST_STOP,
    ST_COAST
  } mode_t;

endpackage

`default_nettype wire

// ===== src/drive_run_command_logic.sv
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Scheme 0: run request starts motor forward, ramping to setpoint.
// - Scheme 0: reverse select reverses via 0 Hz; release returns forward.
// - Scheme 0: reverse select alone never starts the motor.
// - Dropping the run request performs a ramp stop.
// - Forward/reverse-run variant: same-direction request cancels ramp stop and re-accelerates.
// - Variant: opposite-direction request during ramp down ignored until 0 Hz.
// - Variant: no run request active means ramp down and stay stopped.
// - Scheme 1: forward or reverse contact alone runs that way, no zero needed.
// - Scheme 1: both contacts closed ramp stops; both open stays stopped.
// - Scheme 2: stop contact active low; open means ramp stop.
// - Scheme 2: rising edge of forward or reverse pulse latches run with direction.
// - Scheme 2: both pulse inputs closed together cause ramp stop.
// - Scheme 2: single new pulse cancels ramp stop and restarts.
// - Scheme 2: pulse in current running direction changes nothing.
// - Scheme 3: hold contact active low; opening unlatches run and ramps down.
// - Scheme 3: start pulse edge latches run only when off.
// - Scheme 3: reverse select level sets direction whenever the hold contact is closed.
// - Coast stop disables pulses from any source; fast stop decelerates rapidly.
// - Run request honours only the last configured input; stop from same source.
// - Auto DC braking after ramp/fast stop below start frequency for set period.
// - Compound braking above link threshold, off from one cycle after flying restart or DC braking starts.
// - Scheme selector: 0 level, 1 two-wire, 2 pulse with stop, 3 hold.
module drive_run_command_logic
  import drive_cmd_pkg::*;
(
  input  wire logic                 clk,               // 250 MHz clock
  input  wire logic                 sys_rst,           // Synchronous reset, active high
  input  wire logic [7:0]           paddr,             // APB address
  input  wire logic                 psel,              // APB select
  input  wire logic                 penable,           // APB enable
  input  wire logic                 pwrite,            // APB write
  input  wire logic [31:0]          pwdata,            // APB write data
  output logic      [31:0]          prdata,            // APB read data
  output logic                      pready,            // APB ready
  output logic                      pslverr,           // APB error, unmapped address
  input  wire logic [NUM_DIN-1:0]   din,               // Digital input contacts
  input  wire logic                 coast_stop_n,      // Coast stop pin, active low
  input  wire logic                 fast_stop_n,       // Fast stop pin, active low
  input  wire logic [FREQ_W-1:0]    out_freq,          // Output frequency from ramp generator
  input  wire logic                 dc_link_over,      // Link voltage above switch-in threshold
  input  wire logic                 flying_restart,    // Flying restart active
  output logic                      run_cmd,           // Run toward setpoint
  output logic                      reverse_cmd,       // Direction, high for reverse
  output logic                      ramp_stop,         // Ramp stop in progress
  output logic                      fast_stop,         // Fast stop in progress
  output logic                      coast_stop,        // Output pulses disabled
  output logic                      dc_brake_on,       // DC braking active
  output logic                      compound_brake_on, // Compound braking active
  output logic      [FREQ_W-1:0]    compound_current   // Compound braking current
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [NUM_PINS-1:0] s1;
    logic [NUM_PINS-1:0] s2;
    logic [NUM_PINS-1:0] s3;
    mode_t               mode;
    logic                reverse_select;
    logic [PERIOD_W-1:0] dc_cnt;
    logic                dc_done;
    logic                cmp;
    logic [CTRL_W-1:0]   ctrl;
    logic [PERIOD_W-1:0] dc_period;
    logic [FREQ_W-1:0]   dc_freq;
    logic [FREQ_W-1:0]   cmp_cur;
    logic [1:0]          sw_stop;
    logic [31:0]         rdata;
    logic                slverr;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [NUM_PINS-1:0] pins;
  logic [NUM_PINS-1:0] rise;
  logic [1:0]          scheme;
  logic                lvl_a;
  logic                lvl_b;
  logic                lvl_c;
  logic                rise_a;
  logic                rise_b;
  logic                rise_c;
  logic                coast_req;
  logic                fast_req;
  logic                at_zero;
  logic                dc_active;
  logic                auto_dcb;
  logic                is_run;
  logic                is_stopping;
  logic                wr_en;
  logic                setup;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of synchronised inputs

  assign pins   = {fast_stop_n, coast_stop_n, din};
  // Edges only from the second and third stages
  assign rise   = st_r.s2 & ~st_r.s3;
  assign scheme = st_r.ctrl[CTRL_SCHEME_LSB +: 2];

  // One selector per role: rewriting it moves the role, so the last wins
  assign lvl_a  = st_r.s2[st_r.ctrl[CTRL_ROLE_A_LSB +: 2]];
  assign lvl_b  = st_r.s2[st_r.ctrl[CTRL_ROLE_B_LSB +: 2]];
  assign lvl_c  = st_r.s2[st_r.ctrl[CTRL_ROLE_C_LSB +: 2]];
  assign rise_a = rise[st_r.ctrl[CTRL_ROLE_A_LSB +: 2]];
  assign rise_b = rise[st_r.ctrl[CTRL_ROLE_B_LSB +: 2]];
  assign rise_c = rise[st_r.ctrl[CTRL_ROLE_C_LSB +: 2]];

  assign coast_req = ~st_r.s2[PIN_COAST] | st_r.sw_stop[SW_COAST];
  assign fast_req  = ~st_r.s2[PIN_FAST]  | st_r.sw_stop[SW_FAST];
  assign at_zero   = (out_freq == '0);
  assign dc_active = (st_r.dc_cnt != '0);
  assign auto_dcb  = ~st_r.ctrl[CTRL_DCB_DIN] & (st_r.dc_period != '0);
  assign is_run    = (st_r.mode == ST_RUN);
  assign is_stopping = (st_r.mode == ST_RAMP_STOP) | (st_r.mode == ST_FAST_STOP);

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic want_rev;
    want_rev = 1'b0;
    st_nxt   = st_r;

    // Two flops before anything reads the pins, a third for edges
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;

    // Command decode per scheme
    unique case (scheme)
      SCHEME_LEVEL: begin
        if (!st_r.ctrl[CTRL_VARIANT]) begin
          if (is_run) begin
            if (!lvl_a) begin
              st_nxt.mode = ST_RAMP_STOP;
            end else begin
              // Ramp generator passes through 0 Hz on a change
              st_nxt.reverse_select = lvl_c;
            end
          end else if (lvl_a && st_r.mode != ST_FAST_STOP) begin
            // Reverse select alone never gets here
            st_nxt.mode = ST_RUN;
            st_nxt.reverse_select  = lvl_c;
          end
        end else begin
          if (is_run) begin
            if ((lvl_a && lvl_b) || (st_r.reverse_select ? !lvl_b : !lvl_a)) begin
              st_nxt.mode = ST_RAMP_STOP;
            end
          end else if ((lvl_a ^ lvl_b) && st_r.mode != ST_FAST_STOP) begin
            want_rev = lvl_b;
            // Direction change only from standstill; operator waits for it
            if (at_zero || want_rev == st_r.reverse_select) begin
              st_nxt.mode = ST_RUN;
              st_nxt.reverse_select  = want_rev;
            end
          end
        end
      end
      SCHEME_TWO_WIRE: begin
        if (lvl_a ^ lvl_b) begin
          if (st_r.mode != ST_FAST_STOP) begin
            st_nxt.mode = ST_RUN;
            st_nxt.reverse_select  = lvl_b;
          end
        end else if (is_run) begin
          st_nxt.mode = ST_RAMP_STOP;
        end
      end
      SCHEME_PULSE: begin
        if (!lvl_a || (lvl_b && lvl_c)) begin
          if (is_run) begin
            st_nxt.mode = ST_RAMP_STOP;
          end
        end else if ((rise_b || rise_c) && st_r.mode != ST_FAST_STOP) begin
          // Same-direction pulse while running leaves everything as is
          st_nxt.mode = ST_RUN;
          st_nxt.reverse_select  = rise_c;
        end
      end
      SCHEME_HOLD: begin
        if (!lvl_b) begin
          if (is_run) begin
            st_nxt.mode = ST_RAMP_STOP;
          end
        end else begin
          if (!is_run && rise_a && st_r.mode != ST_FAST_STOP) begin
            st_nxt.mode = ST_RUN;
          end
          st_nxt.reverse_select = lvl_c;
        end
      end
    endcase

    // Stop completion at standstill; a restart request at zero wins
    if (is_stopping && at_zero && st_nxt.mode == st_r.mode) begin
      st_nxt.mode = ST_IDLE;
    end

    // Fast stop over any command but a start from idle, coast stop over everything
    if (fast_req && st_r.mode != ST_IDLE) begin
      st_nxt.mode = at_zero ? ST_IDLE : ST_FAST_STOP;
    end
    if (coast_req) begin
      st_nxt.mode = ST_COAST;
    end else if (st_r.mode == ST_COAST) begin
      st_nxt.mode = ST_IDLE;
    end

    // Automatic DC braking, once per stop
    if (dc_active) begin
      st_nxt.dc_cnt = st_r.dc_cnt - 32'h1;
    end
    if (auto_dcb && is_stopping && !st_r.dc_done && !dc_active && out_freq < st_r.dc_freq) begin
      st_nxt.dc_cnt  = st_r.dc_period;
      st_nxt.dc_done = 1'b1;
    end
    if (is_run || st_r.mode == ST_COAST) begin
      st_nxt.dc_cnt  = '0;
      st_nxt.dc_done = 1'b0;
    end

    // Compound braking, off from the cycle after DC braking or flying restart starts
    st_nxt.cmp = (st_r.cmp_cur != '0) & dc_link_over & ~flying_restart & ~dc_active;

    // APB: read data captured in the setup cycle, so it is a flop output
    if (setup) begin
      st_nxt.slverr = 1'b0;
      st_nxt.rdata  = '0;
      unique case (paddr)
        ADDR_CTRL:       st_nxt.rdata[CTRL_W-1:0]   = st_r.ctrl;
        ADDR_STATUS: begin
          st_nxt.rdata[STAT_MODE_LSB +: 3]          = st_r.mode;
          st_nxt.rdata[STAT_REV]                    = st_r.reverse_select;
          st_nxt.rdata[STAT_DCB]                    = dc_active;
          st_nxt.rdata[STAT_CMPD]                   = st_r.cmp;
          st_nxt.rdata[STAT_ZERO]                   = at_zero;
          st_nxt.rdata[STAT_PINS_LSB +: NUM_PINS]   = st_r.s2;
        end
        ADDR_DCB_PERIOD: st_nxt.rdata               = st_r.dc_period;
        ADDR_DCB_FREQ:   st_nxt.rdata[FREQ_W-1:0]   = st_r.dc_freq;
        ADDR_CMPD_CUR:   st_nxt.rdata[FREQ_W-1:0]   = st_r.cmp_cur;
        ADDR_SW_STOP:    st_nxt.rdata[1:0]          = st_r.sw_stop;
        default:         st_nxt.slverr              = 1'b1;
      endcase
    end
    if (wr_en) begin
      unique case (paddr)
        ADDR_CTRL:       st_nxt.ctrl      = pwdata[CTRL_W-1:0];
        ADDR_DCB_PERIOD: st_nxt.dc_period = pwdata;
        ADDR_DCB_FREQ:   st_nxt.dc_freq   = pwdata[FREQ_W-1:0];
        ADDR_CMPD_CUR:   st_nxt.cmp_cur   = pwdata[FREQ_W-1:0];
        ADDR_SW_STOP:    st_nxt.sw_stop   = pwdata[1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r           <= '0;
      // Idle pin levels, so reset release gives no false run or edge
      st_r.s1        <= PINS_RST;
      st_r.s2        <= PINS_RST;
      st_r.s3        <= PINS_RST;
      st_r.mode      <= ST_IDLE;
      st_r.ctrl      <= CTRL_RST;
      st_r.dc_period <= DCB_PERIOD_RST;
      st_r.dc_freq   <= DCB_FREQ_RST;
      st_r.cmp_cur   <= CMPD_CUR_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata            = st_r.rdata;
  assign pready            = 1'b1;
  assign pslverr           = psel & penable & st_r.slverr;
  assign run_cmd           = is_run;
  assign reverse_cmd       = st_r.reverse_select;
  assign ramp_stop         = (st_r.mode == ST_RAMP_STOP);
  assign fast_stop         = (st_r.mode == ST_FAST_STOP);
  assign coast_stop        = (st_r.mode == ST_COAST);
  assign dc_brake_on       = dc_active;
  assign compound_brake_on = st_r.cmp;
  assign compound_current  = st_r.cmp ? st_r.cmp_cur : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic quiet;
  assign quiet = ~coast_req & ~fast_req & ~wr_en;

  sequence s_lvl_start;
    scheme == SCHEME_LEVEL && !st_r.ctrl[CTRL_VARIANT] && quiet && lvl_a
      && (st_r.mode == ST_IDLE || st_r.mode == ST_RAMP_STOP);
  endsequence

  a_level_start: assert property (s_lvl_start |=> run_cmd && reverse_cmd == $past(lvl_c))
    else $error("level scheme did not start on run request");

  a_rev_no_start: assert property (
    scheme == SCHEME_LEVEL && !st_r.ctrl[CTRL_VARIANT] && !lvl_a && !is_run |=> !run_cmd)
    else $error("reverse select alone started the motor");

  a_run_drop_ramp: assert property (
    scheme == SCHEME_LEVEL && !st_r.ctrl[CTRL_VARIANT] && quiet && is_run && !lvl_a |=> ramp_stop)
    else $error("dropping run request did not ramp stop");

  a_opposite_ignored: assert property (
    scheme == SCHEME_LEVEL && st_r.ctrl[CTRL_VARIANT] && st_r.mode == ST_RAMP_STOP && !at_zero
      && (lvl_a ^ lvl_b) && lvl_b != st_r.reverse_select |=> !run_cmd)
    else $error("opposite start accepted during ramp down");

  a_two_wire_both: assert property (
    scheme == SCHEME_TWO_WIRE && quiet && is_run && lvl_a && lvl_b |=> ramp_stop)
    else $error("both contacts closed did not ramp stop");

  a_pulse_stop_open: assert property (
    scheme == SCHEME_PULSE && quiet && is_run && !lvl_a |=> ramp_stop)
    else $error("open stop contact did not ramp stop");

  a_hold_open: assert property (
    scheme == SCHEME_HOLD && quiet && is_run && !lvl_b |=> ramp_stop ##1 (!run_cmd || $past(rise_a)))
    else $error("open hold contact did not unlatch run");

  a_hold_dir: assert property (
    scheme == SCHEME_HOLD && quiet && is_run && lvl_b |=> run_cmd && reverse_cmd == $past(lvl_c))
    else $error("hold scheme lost run or direction");

  a_coast_any: assert property (coast_req |=> coast_stop && !run_cmd)
    else $error("coast stop did not disable pulses");

  a_dcb_length: assert property (
    $rose(dc_brake_on) |-> st_r.dc_cnt == $past(st_r.dc_period) && $past(is_stopping))
    else $error("DC braking started with wrong period or cause");

  a_cmpd_block: assert property (
    flying_restart || dc_brake_on |=> !compound_brake_on)
    else $error("compound braking active with DC braking or flying restart");

  a_edge_single: assert property (rise_a |=> !rise_a)
    else $error("edge event lasted more than one cycle");

  a_two_wire_run: assert property (
    scheme == SCHEME_TWO_WIRE && quiet && (lvl_a ^ lvl_b) && !fast_stop && !coast_stop
      |=> run_cmd && reverse_cmd == $past(lvl_b))
    else $error("single two-wire contact did not run its direction");

  a_fast_decel: assert property (
    fast_req && !coast_req && !at_zero && st_r.mode != ST_IDLE && st_r.mode != ST_COAST |=> fast_stop)
    else $error("fast stop request did not decelerate");

endmodule // drive_run_command_logic

`default_nettype wire

// ===== dv/contact_model.sv
`timescale 1ns/1ps
`default_nettype none
// Operator contacts: stop pins idle released, run contacts idle open
module contact_model (
  input  wire logic       clk,          // Logic clock
  output logic      [3:0] din,          // Run and pulse contacts
  output logic            coast_stop_n, // Coast stop pin
  output logic            fast_stop_n   // Fast stop pin
);
  initial begin
    din          = 4'h0;
    coast_stop_n = 1'b1;
    fast_stop_n  = 1'b1;
  end

  // Contacts move only just after an edge, so the sampling flops never race the bench
  task automatic set(input logic [5:0] p);
    @(posedge clk);
    {fast_stop_n, coast_stop_n, din} <= p;
  endtask
endmodule // contact_model
`default_nettype wire

// ===== dv/drive_run_command_logic_bench.sv
`timescale 1ns/1ps
`default_nettype none
module drive_run_command_logic_bench;
  import drive_cmd_pkg::*;
  logic              clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [3:0]        din;
  logic              coast_n, fast_n, dc_link_over, flying_restart;
  logic [FREQ_W-1:0] out_freq, comp_cur;
  logic              run_cmd, reverse_cmd, ramp_stop, fast_stop, coast_stop, dc_brake_on, comp_on;
  int                failures = 0;
  int                check_count = 0;
  int                n;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  contact_model sw_u (.clk(clk), .din(din), .coast_stop_n(coast_n), .fast_stop_n(fast_n));

  drive_run_command_logic dut_u (
    .clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .din(din),
    .coast_stop_n(coast_n), .fast_stop_n(fast_n), .out_freq(out_freq), .dc_link_over(dc_link_over),
    .flying_restart(flying_restart), .run_cmd(run_cmd), .reverse_cmd(reverse_cmd),
    .ramp_stop(ramp_stop), .fast_stop(fast_stop), .coast_stop(coast_stop),
    .dc_brake_on(dc_brake_on), .compound_brake_on(comp_on), .compound_current(comp_cur));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the watchdog ends a wait for ready
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, e});
  endtask

  // Outputs settle 3 to 4 edges after a contact moves; five leaves margin
  task automatic go(input logic [5:0] p, input logic [15:0] f);
    sw_u.set(p);
    out_freq <= f;
    repeat (5) @(posedge clk);
  endtask

  // Expected order: run, reverse, ramp stop, fast stop, coast
  task automatic st(input logic [5:0] p, input logic [15:0] f, input logic [4:0] e);
    go(p, f);
    @(negedge clk);
    chk({27'h0, run_cmd, reverse_cmd, ramp_stop, fast_stop, coast_stop}, {27'h0, e});
  endtask

  task automatic endt(input string s);
    $display("test %s finished", s);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    failures++;
    results;
  end

  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 8'h0, 32'h0};
    {out_freq, dc_link_over, flying_restart} = '0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rdchk(ADDR_CTRL, 32'h240, 1'b0);
    rdchk(ADDR_DCB_PERIOD, 32'h0, 1'b0);
    rdchk(ADDR_CMPD_CUR, 32'h0, 1'b0);
    rdchk(8'h18, 32'h0, 1'b1);
    apb(1'b1, ADDR_STATUS, 32'h3f);
    rdchk(ADDR_STATUS, 32'h1840, 1'b0);
    apb(1'b1, ADDR_DCB_FREQ, 32'hffff_0010);
    rdchk(ADDR_DCB_FREQ, 32'h10, 1'b0);
    endt("registers");
    st(6'h34, 16'h64, 5'h00);
    st(6'h31, 16'h64, 5'h10);
    st(6'h35, 16'h64, 5'h18);
    st(6'h31, 16'h64, 5'h10);
    st(6'h30, 16'h64, 5'h04);
    st(6'h30, 16'h0, 5'h00);
    apb(1'b1, ADDR_CTRL, 32'h244);
    st(6'h31, 16'h64, 5'h10);
    st(6'h30, 16'h64, 5'h04);
    st(6'h32, 16'h64, 5'h04);
    st(6'h31, 16'h64, 5'h10);
    st(6'h30, 16'h64, 5'h04);
    st(6'h30, 16'h0, 5'h00);
    // Reverse is applied only once standstill is reached
    st(6'h32, 16'h0, 5'h18);
    go(6'h30, 16'h0);
    endt("scheme 0");
    apb(1'b1, ADDR_CTRL, 32'h241);
    st(6'h32, 16'h64, 5'h18);
    st(6'h31, 16'h64, 5'h10);
    st(6'h33, 16'h64, 5'h04);
    st(6'h30, 16'h64, 5'h04);
    st(6'h30, 16'h0, 5'h00);
    endt("scheme 1");
    apb(1'b1, ADDR_CTRL, 32'h242);
    st(6'h31, 16'h64, 5'h00);
    st(6'h33, 16'h64, 5'h10);
    st(6'h31, 16'h64, 5'h10);
    st(6'h35, 16'h64, 5'h18);
    st(6'h31, 16'h64, 5'h18);
    st(6'h35, 16'h64, 5'h18);
    st(6'h33, 16'h64, 5'h10);
    st(6'h37, 16'h64, 5'h04);
    st(6'h31, 16'h64, 5'h04);
    st(6'h33, 16'h64, 5'h10);
    st(6'h30, 16'h64, 5'h04);
    go(6'h30, 16'h0);
    endt("scheme 2");
    apb(1'b1, ADDR_CTRL, 32'h243);
    st(6'h31, 16'h0, 5'h00);
    go(6'h32, 16'h64);
    st(6'h33, 16'h64, 5'h10);
    st(6'h36, 16'h64, 5'h18);
    st(6'h37, 16'h64, 5'h18);
    st(6'h32, 16'h64, 5'h10);
    st(6'h30, 16'h64, 5'h04);
    go(6'h30, 16'h0);
    endt("scheme 3");
    apb(1'b1, ADDR_CTRL, 32'h240);
    st(6'h31, 16'h64, 5'h10);
    st(6'h21, 16'h64, 5'h01);
    st(6'h30, 16'h0, 5'h00);
    st(6'h31, 16'h64, 5'h10);
    st(6'h11, 16'h64, 5'h02);
    st(6'h30, 16'h0, 5'h00);
    st(6'h31, 16'h64, 5'h10);
    apb(1'b1, ADDR_SW_STOP, 32'h1);
    st(6'h31, 16'h64, 5'h01);
    apb(1'b1, ADDR_SW_STOP, 32'h0);
    st(6'h30, 16'h0, 5'h00);
    endt("stops");
    apb(1'b1, ADDR_CTRL, 32'h270);
    st(6'h31, 16'h64, 5'h00);
    st(6'h39, 16'h64, 5'h10);
    st(6'h31, 16'h64, 5'h04);
    go(6'h30, 16'h0);
    endt("source");
    apb(1'b1, ADDR_CTRL, 32'h240);
    apb(1'b1, ADDR_DCB_PERIOD, 32'h5);
    st(6'h31, 16'h64, 5'h10);
    sw_u.set(6'h30);
    out_freq <= 16'h5;
    n = 0;
    repeat (20) begin
      @(negedge clk);
      n += int'(dc_brake_on);
    end
    chk(n, 32'h5);
    go(6'h30, 16'h0);
    // An assigned brake input turns automatic braking off
    apb(1'b1, ADDR_CTRL, 32'h248);
    st(6'h31, 16'h64, 5'h10);
    st(6'h30, 16'h5, 5'h04);
    chk({31'h0, dc_brake_on}, 32'h0);
    go(6'h30, 16'h0);
    apb(1'b1, ADDR_CMPD_CUR, 32'h30);
    dc_link_over <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({15'h0, comp_on, comp_cur}, 32'h10030);
    @(posedge clk);
    flying_restart <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({15'h0, comp_on, comp_cur}, 32'h0);
    endt("braking");
    results;
  end
endmodule // drive_run_command_logic_bench
`default_nettype wire
